// ==== verilog/adcp_regs.vh ====
`ifndef ADCP_REGS_VH
`define ADCP_REGS_VH

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define ADCP_CLK_PERIOD_PS   4000
`define ADCP_PD_DELAY_NS     50
`define ADCP_CONV_TICKS      4'hF
`define ADCP_SAR_LAST_TICK   4'h7
`define ADCP_SW_SAMPLE_TICKS 3'h6
`define ADCP_OSC_SLOW_DIV    8'h19
`define ADCP_OSC_FAST_DIV    8'h0D

// ----------------------------------------------------------------------------
// Bus register offsets (byte addresses)
// ----------------------------------------------------------------------------
`define ADCP_OFS_STATUS      4'h0
`define ADCP_OFS_MASK        4'h4
`define ADCP_OFS_CONFIG      4'h8
`define ADCP_OFS_RESULT      4'hC

// ----------------------------------------------------------------------------
// Interrupt status and mask bits
// ----------------------------------------------------------------------------
`define ADCP_EV_DONE         0
`define ADCP_EV_CFG          1
`define ADCP_EV_AUTOPD       2
`define ADCP_EV_WIDTH        3

// ----------------------------------------------------------------------------
// Control register fields and indices
// ----------------------------------------------------------------------------
`define ADCP_IDX_FIRST       2'h0
`define ADCP_IDX_SECOND      2'h1
`define ADCP_CR0_STARTSW     5
`define ADCP_CR0_EOCLEVEL    4
`define ADCP_CR0_EXTCLK      3
`define ADCP_CR0_SWPD        2
`define ADCP_CR1_OSCFAST     4
`define ADCP_CR1_TWOS        1
`define ADCP_CR_RESET        6'h00
`define ADCP_MASK_RESET      3'h0

`endif

// ==== verilog/adcp_ctrl.v ====
// Behaviour
// - Each result is one 8-bit code, one channel.
// - Dummy read with write low loads defaults.
// - Auto power-down 50 ns after conversion ends.
// - Top two data bits select the control register.
// - Strobes ignored while device select is high.
// - Start pin: fall samples, rise converts.
// - Read fall with select drives result out.
// - Write rise with select captures configuration.
// - Software start: write rise starts sampling.
// - Grounded write strobe means default mode only.
// - Successive approximation against DAC and comparator.
// - Conversion takes 16 conversion clock periods.
// - Level mode frames conversion; pulse mode interrupts.
// - Later samples start on read rise; convert after 6.
// - Host writes index D7..D6 and six control bits.
`timescale 1ns/1ps
`include "adcp_regs.vh"

module adcp_ctrl
(
    input  wire        core_clk,
    input  wire        srst,
    input  wire        cs_n,
    input  wire        rd_n,
    input  wire        wr_n,
    input  wire        sample_convert_pin_n,
    input  wire        ext_clk,
    input  wire        comp_high,
    input  wire [7:0]  data_in,
    output reg  [7:0]  data_out,
    output reg         data_oe,
    output reg         eoc_int_n,
    output reg  [7:0]  dac_code,
    output reg         sample_hold,
    output reg         auto_pd,
    output reg         deep_pd,
    input  wire [3:0]  avs_address,
    input  wire        avs_read,
    input  wire        avs_write,
    input  wire [31:0] avs_writedata,
    output reg  [31:0] avs_readdata,
    output reg         avs_waitrequest,
    output reg         irq
);

    localparam integer PD_CYCLES_I =
        (`ADCP_PD_DELAY_NS * 1000 + `ADCP_CLK_PERIOD_PS - 1)
        / `ADCP_CLK_PERIOD_PS;
    localparam [4:0] PD_CYCLES = PD_CYCLES_I[4:0];

    localparam [1:0] ST_IDLE    = 2'h0;
    localparam [1:0] ST_SAMPLE  = 2'h1;
    localparam [1:0] ST_CONVERT = 2'h2;

    // ------------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------------
    // Bus order: cs, rd, wr, start pin, external clock, comparator, data.
    localparam integer NSYNC = 14;

    wire [NSYNC-1:0] pin_raw;
    reg  [NSYNC-1:0] sync_a;
    reg  [NSYNC-1:0] sync_b;
    reg  [NSYNC-1:0] sync_c;

    assign pin_raw = {data_in, comp_high, ext_clk, sample_convert_pin_n,
                      wr_n, rd_n, cs_n};

    genvar gi;
    generate
        for (gi = 0; gi < NSYNC; gi = gi + 1)
        begin : g_sync
            always @(posedge core_clk)
            begin
                if (srst)
                begin
                    sync_a[gi] <= (gi < 4) ? 1'b1 : 1'b0;
                    sync_b[gi] <= (gi < 4) ? 1'b1 : 1'b0;
                    sync_c[gi] <= (gi < 4) ? 1'b1 : 1'b0;
                end
                else
                begin
                    sync_a[gi] <= pin_raw[gi];
                    sync_b[gi] <= sync_a[gi];
                    sync_c[gi] <= sync_b[gi];
                end
            end
        end
    endgenerate

    wire       cs_s     = sync_b[0];
    wire       sel      = ~cs_s;
    wire       rd_fall  = ~sync_b[1] & sync_c[1];
    wire       rd_rise  = sync_b[1] & ~sync_c[1];
    wire       wr_low   = ~sync_b[2];
    wire       wr_rise  = sync_b[2] & ~sync_c[2];
    wire       st_fall  = ~sync_b[3] & sync_c[3];
    wire       st_rise  = sync_b[3] & ~sync_c[3];
    wire       ext_rise = sync_b[4] & ~sync_c[4];
    wire       comp_s   = sync_b[5];
    wire [7:0] bus_s    = sync_b[13:6];

    // Strobes only count while the device is selected.
    wire rd_fall_sel = rd_fall & sel;
    wire rd_rise_sel = rd_rise & sel;
    wire wr_rise_sel = wr_rise & sel;

    // ------------------------------------------------------------------------
    // Functions
    // ------------------------------------------------------------------------
    function [7:0] adcp_out_code;
        input [7:0] raw;
        input       twos;
        begin
            adcp_out_code = {raw[7] ^ twos, raw[6:0]};
        end
    endfunction

    function [5:0] adcp_field;
        input [7:0] bus;
        input [1:0] idx;
        input [5:0] old;
        begin
            adcp_field = (bus[7:6] == idx) ? bus[5:0] : old;
        end
    endfunction

    // ------------------------------------------------------------------------
    // Control registers
    // ------------------------------------------------------------------------
    reg  [5:0] control_register_first;
    reg  [5:0] control_register_second;
    reg        hw_cfg;
    reg        sw_armed;

    wire start_sw  = control_register_first[`ADCP_CR0_STARTSW];
    wire eoc_level = control_register_first[`ADCP_CR0_EOCLEVEL];
    wire clk_ext   = control_register_first[`ADCP_CR0_EXTCLK];
    wire swpd      = control_register_first[`ADCP_CR0_SWPD];
    wire osc_fast  = control_register_second[`ADCP_CR1_OSCFAST];
    wire out_twos  = control_register_second[`ADCP_CR1_TWOS];

    wire dummy_rd  = rd_fall_sel & wr_low;

    always @(posedge core_clk)
    begin
        if (srst)
        begin
            control_register_first  <= `ADCP_CR_RESET;
            control_register_second <= `ADCP_CR_RESET;
            hw_cfg                  <= 1'b0;
        end
        else if (dummy_rd)
        begin
            // A write strobe stuck low never rises, so defaults rule.
            control_register_first  <= `ADCP_CR_RESET;
            control_register_second <= `ADCP_CR_RESET;
            hw_cfg                  <= 1'b1;
        end
        else if (wr_rise_sel)
        begin
            control_register_first  <= adcp_field(bus_s,
                `ADCP_IDX_FIRST, control_register_first);
            control_register_second <= adcp_field(bus_s,
                `ADCP_IDX_SECOND, control_register_second);
            hw_cfg                  <= 1'b0;
        end
    end

    // ------------------------------------------------------------------------
    // Conversion clock
    // ------------------------------------------------------------------------
    reg  [7:0] osc_cnt;
    reg        osc_tick;
    wire [7:0] osc_div = osc_fast ? `ADCP_OSC_FAST_DIV : `ADCP_OSC_SLOW_DIV;

    always @(posedge core_clk)
    begin
        if (srst || osc_cnt >= osc_div - 8'h01)
        begin
            osc_cnt  <= 8'h00;
            osc_tick <= ~srst;
        end
        else
        begin
            osc_cnt  <= osc_cnt + 8'h01;
            osc_tick <= 1'b0;
        end
    end

    wire conv_tick = clk_ext ? ext_rise : osc_tick;

    // ------------------------------------------------------------------------
    // Sampling and conversion sequencer
    // ------------------------------------------------------------------------
    reg [1:0] state;
    reg [3:0] conv_cnt;
    reg [2:0] samp_cnt;
    reg [7:0] result;
    reg       done_pulse;
    reg       int_hold;
    reg [1:0] cmp_wait;
    reg       tick_pend;

    // The comparator reaches us through two flops, so a tick that comes
    // right after a new trial code is held back until the answer settles.
    wire conv_go   = (conv_tick | tick_pend) & (cmp_wait == 2'h0);
    // The write that turns software start on must start sampling too.
    wire wr_sw     = wr_rise_sel & ((bus_s[7:6] == `ADCP_IDX_FIRST)
                     ? bus_s[`ADCP_CR0_STARTSW] : start_sw);
    wire sw_start  = wr_sw |
                     (start_sw & sw_armed & rd_rise_sel);
    wire hw_start  = ~start_sw & st_fall;
    wire start_smp = (state != ST_CONVERT) & (sw_start | hw_start);
    wire [7:0] bit_mask = 8'h80 >> conv_cnt[2:0];
    wire [7:0] sar_keep = comp_s ? dac_code : (dac_code & ~bit_mask);
    wire [7:0] sar_next = (conv_cnt[2:0] == 3'h7) ? sar_keep
                          : (sar_keep | (bit_mask >> 1));

    always @(posedge core_clk)
    begin
        if (srst)
        begin
            state       <= ST_IDLE;
            conv_cnt    <= 4'h0;
            samp_cnt    <= 3'h0;
            result      <= 8'h00;
            dac_code    <= 8'h00;
            sample_hold <= 1'b0;
            done_pulse  <= 1'b0;
            sw_armed    <= 1'b0;
            cmp_wait    <= 2'h0;
            tick_pend   <= 1'b0;
        end
        else
        begin
            done_pulse <= 1'b0;
            if (cmp_wait != 2'h0)
            begin
                cmp_wait <= cmp_wait - 2'h1;
            end
            tick_pend <= (state == ST_CONVERT) & (conv_tick | tick_pend)
                         & (cmp_wait != 2'h0);
            if (wr_sw)
            begin
                sw_armed <= 1'b1;
            end
            else if (!start_sw)
            begin
                sw_armed <= 1'b0;
            end
            case (state)
                ST_IDLE:
                begin
                    if (start_smp)
                    begin
                        state       <= ST_SAMPLE;
                        samp_cnt    <= 3'h0;
                        sample_hold <= 1'b1;
                    end
                end
                ST_SAMPLE:
                begin
                    if (start_sw && conv_tick)
                    begin
                        samp_cnt <= samp_cnt + 3'h1;
                    end
                    if ((!start_sw && st_rise) ||
                        (start_sw && conv_tick &&
                         samp_cnt == `ADCP_SW_SAMPLE_TICKS - 3'h1))
                    begin
                        state       <= ST_CONVERT;
                        conv_cnt    <= 4'h0;
                        sample_hold <= 1'b0;
                        dac_code    <= 8'h80;
                        cmp_wait    <= 2'h3;
                    end
                end
                ST_CONVERT:
                begin
                    if (conv_go)
                    begin
                        conv_cnt <= conv_cnt + 4'h1;
                        if (conv_cnt <= `ADCP_SAR_LAST_TICK)
                        begin
                            dac_code <= sar_next;
                            cmp_wait <= 2'h3;
                        end
                        if (conv_cnt == `ADCP_SAR_LAST_TICK)
                        begin
                            result <= sar_next;
                        end
                        if (conv_cnt == `ADCP_CONV_TICKS)
                        begin
                            state      <= ST_IDLE;
                            done_pulse <= 1'b1;
                        end
                    end
                end
                default:
                begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------------
    // End-of-conversion pin, power-down and data bus
    // ------------------------------------------------------------------------
    reg [4:0] pd_cnt;
    reg       pd_run;
    reg       pd_enter;

    always @(posedge core_clk)
    begin
        if (srst)
        begin
            eoc_int_n <= 1'b1;
            int_hold  <= 1'b0;
            pd_cnt    <= 5'h00;
            pd_run    <= 1'b0;
            pd_enter  <= 1'b0;
            auto_pd   <= 1'b0;
            deep_pd   <= 1'b0;
            data_out  <= 8'h00;
            data_oe   <= 1'b0;
        end
        else
        begin
            // Pulse mode holds the pulse for one conversion clock period.
            if (eoc_level)
            begin
                eoc_int_n <= (state != ST_CONVERT);
                int_hold  <= 1'b0;
            end
            else if (done_pulse)
            begin
                eoc_int_n <= 1'b0;
                int_hold  <= 1'b1;
            end
            else if (int_hold && conv_tick)
            begin
                eoc_int_n <= 1'b1;
                int_hold  <= 1'b0;
            end
            else if (!int_hold)
            begin
                eoc_int_n <= 1'b1;
            end
            pd_enter <= 1'b0;
            if (start_smp)
            begin
                pd_run  <= 1'b0;
                auto_pd <= 1'b0;
            end
            else if (done_pulse)
            begin
                pd_run <= 1'b1;
                pd_cnt <= 5'h01;
            end
            else if (pd_run)
            begin
                if (pd_cnt >= PD_CYCLES - 5'h01)
                begin
                    pd_run   <= 1'b0;
                    auto_pd  <= 1'b1;
                    pd_enter <= 1'b1;
                end
                else
                begin
                    pd_cnt <= pd_cnt + 5'h01;
                end
            end
            deep_pd <= swpd | cs_s;
            if (rd_fall_sel)
            begin
                data_out <= adcp_out_code(result, out_twos);
                data_oe  <= 1'b1;
            end
            else if (rd_rise || !sel)
            begin
                data_oe <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------------
    // Avalon-MM slave and interrupt
    // ------------------------------------------------------------------------
    reg  [`ADCP_EV_WIDTH-1:0] ev_status;
    reg  [`ADCP_EV_WIDTH-1:0] ev_mask;
    wire [`ADCP_EV_WIDTH-1:0] ev_set = {pd_enter, wr_rise_sel, done_pulse};
    wire                      bus_wr = avs_write & ~avs_waitrequest;
    wire [`ADCP_EV_WIDTH-1:0] ev_clr =
        (bus_wr && avs_address == `ADCP_OFS_STATUS)
        ? avs_writedata[`ADCP_EV_WIDTH-1:0] : {`ADCP_EV_WIDTH{1'b0}};

    always @(posedge core_clk)
    begin
        if (srst)
        begin
            ev_status       <= {`ADCP_EV_WIDTH{1'b0}};
            ev_mask         <= `ADCP_MASK_RESET;
            irq             <= 1'b0;
            avs_waitrequest <= 1'b1;
            avs_readdata    <= 32'h0000_0000;
        end
        else
        begin
            // A new event beats a clear arriving in the same cycle.
            ev_status <= (ev_status & ~ev_clr) | ev_set;
            irq       <= |(((ev_status & ~ev_clr) | ev_set) & ev_mask);
            if (bus_wr && avs_address == `ADCP_OFS_MASK)
            begin
                ev_mask <= avs_writedata[`ADCP_EV_WIDTH-1:0];
            end
            if ((avs_read || avs_write) && avs_waitrequest)
            begin
                avs_waitrequest <= 1'b0;
                case (avs_address)
                    `ADCP_OFS_STATUS:
                        avs_readdata <= {29'h0, ev_status};
                    `ADCP_OFS_MASK:
                        avs_readdata <= {29'h0, ev_mask};
                    `ADCP_OFS_CONFIG:
                        avs_readdata <= {15'h0, hw_cfg, 2'h0,
                                         control_register_second,
                                         2'h0, control_register_first};
                    `ADCP_OFS_RESULT:
                        avs_readdata <= {20'h0, deep_pd, auto_pd, state,
                                         adcp_out_code(result, out_twos)};
                    default:
                        avs_readdata <= 32'h0000_0000;
                endcase
            end
            else
            begin
                avs_waitrequest <= 1'b1;
            end
        end
    end

endmodule

// ==== dv/adcp_ctrl_asserts.sv ====
`timescale 1ns/1ps
module adcp_chk
(
    input wire       core_clk,
    input wire       srst,
    input wire       cs_n,
    input wire       rd_n,
    input wire [7:0] data_out,
    input wire       data_oe,
    input wire [7:0] dac_code,
    input wire       sample_hold,
    input wire       auto_pd,
    input wire       deep_pd,
    input wire       avs_read,
    input wire       avs_write,
    input wire       avs_waitrequest
);
    // --------
    // Cycles since conversion began; saturates so it never wraps.
    // --------
    reg [5:0] conv_age;
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (srst);
    always @(posedge core_clk)
    begin
        if (srst || $fell(sample_hold))
            conv_age <= 6'h00;
        else if (conv_age != 6'h3F)
            conv_age <= conv_age + 6'h01;
    end
    sequence bus_req;
        (avs_read || avs_write) && avs_waitrequest;
    endsequence
    sequence conv_begin;
        $fell(sample_hold);
    endsequence
    chk_bus_answer: assert property (bus_req |=> !avs_waitrequest)
        else $error("waitrequest stayed high after a request");
    chk_bus_gap: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest low for more than one cycle");
    chk_oe_select: assert property (cs_n [*6] |-> !data_oe)
        else $error("bus driven while deselected");
    chk_oe_read: assert property (rd_n [*6] |-> !data_oe)
        else $error("bus driven without a read strobe");
    chk_oe_stable: assert property (
        data_oe && $past(data_oe) |-> $stable(data_out))
        else $error("result changed while driven");
    chk_sar_first: assert property (
        conv_begin |-> ##[0:2] (dac_code == 8'h80))
        else $error("first trial code not midscale");
    chk_pd_delay: assert property (
        $rose(auto_pd) |-> conv_age >= 6'h1C)
        else $error("power-down entered too early");
    chk_pd_exit: assert property (
        $rose(sample_hold) |-> ##[0:1] !auto_pd)
        else $error("power-down kept while sampling");
    chk_deep_select: assert property (cs_n [*5] |-> deep_pd)
        else $error("no deep power-down while deselected");
endmodule

bind adcp_ctrl adcp_chk u_chk
(
    .core_clk        (core_clk),
    .srst            (srst),
    .cs_n            (cs_n),
    .rd_n            (rd_n),
    .data_out        (data_out),
    .data_oe         (data_oe),
    .dac_code        (dac_code),
    .sample_hold     (sample_hold),
    .auto_pd         (auto_pd),
    .deep_pd         (deep_pd),
    .avs_read        (avs_read),
    .avs_write       (avs_write),
    .avs_waitrequest (avs_waitrequest)
);

// ==== dv/adcp_front_model.sv ====
`timescale 1ns/1ps
module adcp_front_model
(
    input  wire       core_clk,
    input  wire [7:0] vin,
    input  wire [7:0] dac_code,
    input  wire       host_oe,
    input  wire [7:0] host_d,
    input  wire [7:0] data_out,
    input  wire       data_oe,
    output wire       comp_high,
    output wire [7:0] data_in
);
    // --------
    // The bus has no pull, so a released bus flips every cycle.
    // --------
    reg [7:0] float_val = 8'hA5;
    always @(posedge core_clk)
        float_val <= ~float_val;
    assign data_in = host_oe ? host_d :
                     (data_oe ? data_out : float_val);
    assign comp_high = (vin >= dac_code);
endmodule

// ==== dv/tb_top.sv ====
`timescale 1ns/1ps
`include "adcp_regs.vh"
module tb_top;
    reg         core_clk = 1'b0;
    reg         srst = 1'b1;
    reg         cs_n = 1'b1;
    reg         rd_n = 1'b1;
    reg         wr_n = 1'b1;
    reg         start_n = 1'b1;
    reg  [2:0]  ext_div = 3'h0;
    reg  [7:0]  vin = 8'h00;
    reg         host_oe = 1'b0;
    reg  [7:0]  host_d = 8'h00;
    reg  [3:0]  avs_address = 4'h0;
    reg         avs_read = 1'b0;
    reg         avs_write = 1'b0;
    reg  [31:0] avs_writedata = 32'h0;
    wire        comp_high;
    wire [7:0]  data_in;
    wire [7:0]  data_out;
    wire        data_oe;
    wire        eoc_int_n;
    wire [7:0]  dac_code;
    wire        sample_hold;
    wire        auto_pd;
    wire [31:0] avs_readdata;
    wire        avs_waitrequest;
    wire        irq;
    reg         oe_q = 1'b0;
    reg  [63:0] exp_bus[$];
    reg  [7:0]  exp_pin[$];
    reg  [63:0] w;
    reg  [7:0]  v;
    integer     failures = 0;
    integer     cmp_count = 0;
    integer     i;
    integer     n;

    adcp_ctrl uut
    (
        .core_clk(core_clk), .srst(srst), .cs_n(cs_n), .rd_n(rd_n),
        .wr_n(wr_n), .sample_convert_pin_n(start_n), .ext_clk(ext_div[2]),
        .comp_high(comp_high), .data_in(data_in), .data_out(data_out),
        .data_oe(data_oe), .eoc_int_n(eoc_int_n), .dac_code(dac_code),
        .sample_hold(sample_hold), .auto_pd(auto_pd), .deep_pd(),
        .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .irq(irq)
    );
    adcp_front_model front
    (
        .core_clk(core_clk), .vin(vin), .dac_code(dac_code),
        .host_oe(host_oe), .host_d(host_d), .data_out(data_out),
        .data_oe(data_oe), .comp_high(comp_high), .data_in(data_in)
    );

    initial forever #2 core_clk = ~core_clk;
    always @(posedge core_clk)
        ext_div <= ext_div + 3'h1;

    task cmp(input [31:0] got, input [31:0] exp);
    begin
        cmp_count = cmp_count + 1;
        if (got !== exp)
        begin
            failures = failures + 1;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    end
    endtask

    // --------
    // Results are queued by the drivers and matched here when they show.
    // --------
    always @(posedge core_clk)
    begin
        oe_q <= data_oe;
        if (avs_read && avs_waitrequest === 1'b0 && exp_bus.size() > 0)
        begin
            w = exp_bus.pop_front();
            cmp(avs_readdata & w[63:32], w[31:0]);
        end
        if (data_oe === 1'b1 && oe_q === 1'b0 && exp_pin.size() > 0)
            cmp({24'h0, data_out}, {24'h0, exp_pin.pop_front()});
    end

    task bus(input wr, input [3:0] a, input [31:0] d);
    begin
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= !wr;
        n = 0;
        @(posedge core_clk);
        while (avs_waitrequest !== 1'b0 && n < 50)
        begin
            n = n + 1;
            @(posedge core_clk);
        end
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        cmp({31'h0, n < 50}, 32'h1);
        @(posedge core_clk);
    end
    endtask

    task rd(input [3:0] a, input [31:0] m, input [31:0] e);
    begin
        exp_bus.push_back({m, e});
        bus(1'b0, a, 32'h0);
    end
    endtask

    task pwr(input [7:0] b, input sel_n);
    begin
        cs_n <= sel_n;
        host_d <= b;
        host_oe <= 1'b1;
        repeat (4) @(posedge core_clk);
        wr_n <= 1'b0;
        repeat (4) @(posedge core_clk);
        wr_n <= 1'b1;
        repeat (4) @(posedge core_clk);
        host_oe <= 1'b0;
        cs_n <= 1'b0;
        repeat (4) @(posedge core_clk);
    end
    endtask

    task strobe_rd;
    begin
        rd_n <= 1'b0;
        repeat (8) @(posedge core_clk);
        rd_n <= 1'b1;
        repeat (6) @(posedge core_clk);
    end
    endtask

    task wait_hi(input sel);
    begin
        n = 0;
        while ((sel ? sample_hold : auto_pd) !== 1'b1 && n < 3000)
        begin
            n = n + 1;
            @(posedge core_clk);
        end
        cmp({31'h0, n < 3000}, 32'h1);
    end
    endtask

    task wrap_up;
    begin
        $display("comparisons %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    end
    endtask

    initial
    begin
        #100000;
        failures = failures + 1;
        wrap_up;
    end

    initial
    begin
        i = $urandom(32'h0989);
        repeat (4) @(posedge core_clk);
        srst <= 1'b0;
        @(posedge core_clk);
        rd(`ADCP_OFS_CONFIG, 32'hFFFFFFFF, 32'h0);
        rd(`ADCP_OFS_MASK, 32'hFFFFFFFF, 32'h0);
        rd(4'h2, 32'hFFFFFFFF, 32'h0);
        $display("register reset test done");
        pwr(8'h42, 1'b0);
        pwr(8'hC3, 1'b0);
        pwr(8'h1C, 1'b1);
        rd(`ADCP_OFS_CONFIG, 32'h3F3F, 32'h0200);
        rd(`ADCP_OFS_STATUS, 32'h2, 32'h2);
        $display("configuration test done");
        for (i = 0; i < 2; i = i + 1)
        begin
            bus(1'b1, `ADCP_OFS_STATUS, 32'h7);
            bus(1'b1, `ADCP_OFS_MASK, i);
            pwr(i ? 8'h18 : 8'h00, 1'b0);
            pwr(i ? 8'h52 : 8'h40, 1'b0);
            v = 8'($urandom);
            vin <= v;
            start_n <= 1'b0;
            repeat (6) @(posedge core_clk);
            cmp({31'h0, sample_hold}, 32'h1);
            start_n <= 1'b1;
            repeat (10) @(posedge core_clk);
            cmp({31'h0, eoc_int_n}, {31'h0, i == 0});
            cmp({31'h0, sample_hold}, 32'h0);
            wait_hi(1'b0);
            cmp({31'h0, irq}, {31'h0, i == 1});
            exp_pin.push_back(v ^ {i[0], 7'h00});
            strobe_rd;
            bus(1'b1, `ADCP_OFS_STATUS, 32'h7);
            repeat (3) @(posedge core_clk);
            cmp({31'h0, irq}, 32'h0);
            $display("hardware start test done");
        end
        pwr(8'h40, 1'b0);
        v = 8'($urandom);
        vin <= v;
        pwr(8'h20, 1'b0);
        n = 0;
        while (sample_hold === 1'b1 && n < 400)
        begin
            n = n + 1;
            @(posedge core_clk);
        end
        cmp({31'h0, n >= 118 && n <= 150}, 32'h1);
        wait_hi(1'b0);
        exp_pin.push_back(v);
        strobe_rd;
        cmp({31'h0, sample_hold}, 32'h1);
        $display("software start test done");
        wr_n <= 1'b0;
        repeat (4) @(posedge core_clk);
        strobe_rd;
        cs_n <= 1'b1;
        repeat (4) @(posedge core_clk);
        wr_n <= 1'b1;
        repeat (4) @(posedge core_clk);
        rd(`ADCP_OFS_CONFIG, 32'h3F3F, 32'h0);
        $display("default load test done");
        wrap_up;
    end
endmodule
